/* verilog/qwtws_pkg.sv */
package qwtws_pkg;
  // Fixed upper part of the bus address
  localparam logic [4:0] QWTWS_ADDR_FIXED = 5'h0b;
  // Instruction byte field positions
  localparam int QWTWS_CHAN_HI_POS  = 6;
  localparam int QWTWS_CHAN_LO_POS  = 5;
  localparam int QWTWS_MID_RST_POS  = 4;
  localparam int QWTWS_PWR_DN_POS   = 3;
  localparam int QWTWS_OUT_2ND_POS  = 2;
  localparam int QWTWS_OUT_1ST_POS  = 1;
  // Reset values
  localparam logic [7:0] QWTWS_MIDSCALE = 8'h80;
  localparam logic       QWTWS_OUT_RST  = 1'h0;
  // Bit index of the acknowledge slot, after eight data bits
  localparam logic [3:0] QWTWS_ACK_SLOT = 4'h8;
  // Link clock: the master reloads its divider with this count, so a half period lasts this count plus one clocks
  localparam int         QWTWS_SCL_PERIOD_NS = 800;
  localparam int         QWTWS_CLK_PERIOD_NS = 100;
  localparam logic [7:0] QWTWS_HALF_CYC =
    8'((QWTWS_SCL_PERIOD_NS / QWTWS_CLK_PERIOD_NS) / 2);
  // Master register map (APB byte addresses)
  localparam logic [7:0] QWTWS_REG_CMD  = 8'h00;
  localparam logic [7:0] QWTWS_REG_STAT = 8'h04;
  localparam logic [7:0] QWTWS_REG_RDAT = 8'h08;
  // Command register fields
  localparam int QWTWS_CMD_GO_POS   = 31;
  localparam int QWTWS_CMD_RD_POS   = 30;
  localparam int QWTWS_CMD_NODATA   = 29;
  localparam int QWTWS_CMD_ADDR_POS = 16;
  localparam int QWTWS_CMD_INS_POS  = 8;
endpackage : qwtws_pkg

/* verilog/qwtws_if.sv */
`timescale 1ns/1ps
interface qwtws_if;
  logic scl_o;    // Master clock drive level
  logic scl_oe;   // Master drives clock low
  logic sda_m_o;  // Master data level
  logic sda_m_oe; // Master drives data
  logic sda_s_o;  // Slave data level
  logic sda_s_oe; // Slave drives data
  logic scl;      // Resolved clock wire
  logic sda;      // Resolved data wire
  // Open drain wires with pull-up
  assign scl = !(scl_oe && !scl_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  modport master (output scl_o, scl_oe, sda_m_o, sda_m_oe,
                  input scl, sda);
  modport slave  (output sda_s_o, sda_s_oe, input scl, sda);
endinterface : qwtws_if

/* verilog/qwtws_slave.sv */
`timescale 1ns/1ps
// Behaviour
// - Active only when interface select is high
// - Address 01011 plus two address pins
// - Start then address byte with direction
// - Ack matching address on ninth pulse
// - Direction one reads, zero writes
// - Second write byte is instruction byte
// - Channel pair 00..11 selects channels 1..4
// - Midscale bit overwrites selected wiper
// - Power-down bit shuts selected channel, keeps value
// - Bit per channel; pin shuts all
// - Instruction bits set second, first outputs
// - Logic outputs reset to zero
// - Byte after instruction loads wiper
// - Data changes only while clock low
// - Read returns last selected wiper immediately
// - Address plus instruction selects channel
// - Stop is data rising while clock high
// - Master nacks last read byte, then stops
// - Every further data byte updates wiper
// - New instruction needs new transfer
// - Repeated reads while master acks
// - Instruction alone updates outputs, power-down, midscale
module qwtws_slave (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  // Pins
  input  wire logic       i_interface_select_pin,
  input  wire logic       i_bus_addr_pin_low,
  input  wire logic       i_bus_addr_pin_high,
  input  wire logic       i_global_power_down_n,
  // Link
  qwtws_if.slave          bus,
  // Device state
  output logic [31:0]     o_wiper_register,
  output logic [3:0]      o_power_down,
  output logic            o_logic_out_first,
  output logic            o_logic_out_second
);
  typedef enum logic [4:0] {
    QWTWS_S_IDLE = 5'h01, // Waiting for start
    QWTWS_S_ADDR = 5'h02, // Shifting address byte
    QWTWS_S_INS  = 5'h04, // Shifting instruction byte
    QWTWS_S_DATA = 5'h08, // Shifting wiper bytes
    QWTWS_S_READ = 5'h10  // Sending wiper bytes
  } qwtws_st_t;

  // Three-stage sampling of the pins
  logic [2:0] scl_sy_r;
  logic [2:0] sda_sy_r;
  // Pin stages: power down, select, address high, address low
  logic [3:0] pin_s0_r;
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic [3:0] pin_r;    // Filtered pin levels
  logic       scl_r;    // Filtered clock level
  logic       sda_r;    // Filtered data level
  qwtws_st_t  st_r;
  logic [3:0] bit_r;    // Bit index within nine slots
  logic [7:0] sh_r;     // Receive shift register
  logic [7:0] tx_r;     // Transmit shift register
  logic       ack_r;    // Acknowledge due at next clock fall
  logic       drv_r;    // Driving data low
  logic [1:0] chan_r;   // Selected channel
  logic [7:0] wip_r [4];
  logic [3:0] pd_r;     // Per-channel power-down
  logic       out1_r;
  logic       out2_r;

  // Filter: a change counts once stages two and three agree
  wire scl_ok   = (scl_sy_r[1] == scl_sy_r[2]);
  wire sda_ok   = (sda_sy_r[1] == sda_sy_r[2]);
  wire scl_rise = scl_ok && scl_sy_r[2] && !scl_r;
  wire scl_fall = scl_ok && !scl_sy_r[2] && scl_r;
  // Start and stop are seen only while the clock stays high
  wire start_ev = sda_ok && !sda_sy_r[2] && sda_r && scl_r && !scl_fall;
  wire stop_ev  = sda_ok && sda_sy_r[2] && !sda_r && scl_r && !scl_fall;
  // Pins come from outside the clock domain
  wire [3:0] pin_raw  = {i_global_power_down_n, i_interface_select_pin,
                         i_bus_addr_pin_high, i_bus_addr_pin_low};
  wire enabled  = pin_r[2];
  wire [6:0] own_addr = {qwtws_pkg::QWTWS_ADDR_FIXED, pin_r[1:0]};
  wire [7:0] byte_in  = {sh_r[6:0], sda_r};
  wire       last_bit = (bit_r == 4'h7);
  wire       in_ack   = (bit_r == qwtws_pkg::QWTWS_ACK_SLOT);
  wire [1:0] ins_chan = byte_in[qwtws_pkg::QWTWS_CHAN_HI_POS -:2];

  // Input sampling
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      scl_sy_r <= 3'h7;
      sda_sy_r <= 3'h7;
      scl_r    <= 1'h1;
      sda_r    <= 1'h1;
      // Power pin idle high, interface off until the pins settle
      pin_s0_r <= 4'h8;
      pin_s1_r <= 4'h8;
      pin_s2_r <= 4'h8;
      pin_r    <= 4'h8;
    end
    else
    begin
      scl_sy_r <= {scl_sy_r[1:0], bus.scl};
      sda_sy_r <= {sda_sy_r[1:0], bus.sda};
      pin_s0_r <= pin_raw;
      pin_s1_r <= pin_s0_r;
      pin_s2_r <= pin_s1_r;
      // A pin level counts once stages two and three agree
      pin_r    <= (pin_s1_r & pin_s2_r) | (pin_r & (pin_s1_r | pin_s2_r));
      if (scl_ok)
        scl_r <= scl_sy_r[2];
      if (sda_ok)
        sda_r <= sda_sy_r[2];
    end
  end

  // Protocol engine; data is sampled on clock rise, driven on fall
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      st_r   <= QWTWS_S_IDLE;
      bit_r  <= 4'h0;
      sh_r   <= 8'h00;
      tx_r   <= 8'h00;
      ack_r  <= 1'h0;
      drv_r  <= 1'h0;
      chan_r <= 2'h0;
      pd_r   <= 4'h0;
      out1_r <= qwtws_pkg::QWTWS_OUT_RST;
      out2_r <= qwtws_pkg::QWTWS_OUT_RST;
      for (int i = 0; i < 4; i++)
        wip_r[i] <= qwtws_pkg::QWTWS_MIDSCALE;
    end
    else if (!enabled || stop_ev)
    begin
      // Stop or deselect ends everything; instruction effects stay
      st_r  <= QWTWS_S_IDLE;
      drv_r <= 1'h0;
      ack_r <= 1'h0;
    end
    else if (start_ev)
    begin
      // Repeated start restarts the address phase
      st_r  <= QWTWS_S_ADDR;
      bit_r <= 4'h0;
      drv_r <= 1'h0;
      ack_r <= 1'h0;
    end
    else if (st_r != QWTWS_S_IDLE)
    begin
      if (scl_rise)
      begin
        if (!in_ack)
        begin
          sh_r <= byte_in;
          bit_r <= bit_r + 4'h1;
          if (st_r == QWTWS_S_READ)
            tx_r <= {tx_r[6:0], 1'h0};
        end
        else
        begin
          bit_r <= 4'h0;
          // Master nack ends a read; slave drives nothing more
          if (st_r == QWTWS_S_READ && sda_r)
            st_r <= QWTWS_S_IDLE;
        end
        if (last_bit)
        begin
          case (st_r)
            QWTWS_S_ADDR:
            begin
              if (byte_in[7:1] == own_addr)
              begin
                ack_r <= 1'h1;
                st_r  <= byte_in[0] ? QWTWS_S_READ : QWTWS_S_INS;
              end
              else
                st_r <= QWTWS_S_IDLE;
            end
            QWTWS_S_INS:
            begin
              ack_r  <= 1'h1;
              chan_r <= ins_chan;
              // Outputs take effect without touching wipers
              out2_r <= byte_in[qwtws_pkg::QWTWS_OUT_2ND_POS];
              out1_r <= byte_in[qwtws_pkg::QWTWS_OUT_1ST_POS];
              pd_r[ins_chan] <= byte_in[qwtws_pkg::QWTWS_PWR_DN_POS];
              if (byte_in[qwtws_pkg::QWTWS_MID_RST_POS])
                wip_r[ins_chan] <= qwtws_pkg::QWTWS_MIDSCALE;
              st_r <= QWTWS_S_DATA;
            end
            QWTWS_S_DATA:
            begin
              ack_r <= 1'h1;
              wip_r[chan_r] <= byte_in;
            end
            default:
            begin
              ack_r <= 1'h0;
            end
          endcase
        end
      end
      else if (scl_fall)
      begin
        // Drive changes only after the clock has gone low
        if (ack_r && in_ack)
        begin
          drv_r <= 1'h1;
          ack_r <= 1'h0;
        end
        else if (st_r == QWTWS_S_READ && bit_r == 4'h0)
        begin
          // Load a fresh copy for each byte of a repeated read
          tx_r  <= wip_r[chan_r];
          drv_r <= !wip_r[chan_r][7];
        end
        else if (st_r == QWTWS_S_READ && !in_ack)
          drv_r <= !tx_r[7];
        else
          drv_r <= 1'h0;
      end
    end
    else
      drv_r <= 1'h0;
  end

  // Open-drain: only pull low
  assign bus.sda_s_o  = 1'h0;
  assign bus.sda_s_oe = drv_r;

  // Device outputs; shutdown pin overrides all channels
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_chan
      assign o_wiper_register[8*g +: 8] = wip_r[g];
      assign o_power_down[g] = pd_r[g] || !pin_r[3];
    end
  endgenerate
  assign o_logic_out_first  = out1_r;
  assign o_logic_out_second = out2_r;
endmodule : qwtws_slave

/* verilog/qwtws_master.sv */
`timescale 1ns/1ps
module qwtws_master (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Link
  qwtws_if.master          bus
);
  typedef enum logic [5:0] {
    QWTWS_M_IDLE  = 6'h01, // Nothing to do
    QWTWS_M_START = 6'h02, // Data falls while clock high
    QWTWS_M_BIT   = 6'h04, // Clock low half of a slot
    QWTWS_M_HIGH  = 6'h08, // Clock high half of a slot
    QWTWS_M_STOP0 = 6'h10, // Data low, clock low
    QWTWS_M_STOP1 = 6'h20  // Clock high, then data rises
  } qwtws_mst_t;

  qwtws_mst_t  st_r;
  logic [7:0]  div_r;     // Half-period divider
  logic [3:0]  bit_r;     // Slot within byte
  logic [1:0]  byte_r;    // Byte number in frame
  logic [7:0]  tx_r;      // Byte being sent
  logic [7:0]  rx_r;      // Byte being received
  logic [7:0]  ins_r;     // Instruction byte
  logic [7:0]  dat_r;     // Wiper data byte
  logic [6:0]  addr_r;    // Target address
  logic        rd_r;      // Read transfer
  logic        nodata_r;  // Write without data byte
  logic        nack_r;    // Slave did not ack
  logic        scl_r;
  logic        sda_r;
  logic        sda_q_r;   // Data drive, one clock behind
  logic        done_r;    // Last transfer finished
  logic [7:0]  rdat_r;

  wire tick    = (div_r == 8'h00);
  wire busy    = (st_r != QWTWS_M_IDLE);
  wire wr_cmd  = i_psel && i_penable && i_pwrite &&
                 (i_paddr == qwtws_pkg::QWTWS_REG_CMD);
  wire go      = wr_cmd && i_pwdata[qwtws_pkg::QWTWS_CMD_GO_POS] && !busy;
  wire ack_slot = (bit_r == qwtws_pkg::QWTWS_ACK_SLOT);
  // Last byte: the read byte when reading, else instruction/data
  wire last_byte = rd_r ? (byte_r == 2'h1)
                 : (nodata_r ? (byte_r == 2'h1) : (byte_r == 2'h2));
  wire mapped  = (i_paddr == qwtws_pkg::QWTWS_REG_CMD) ||
                 (i_paddr == qwtws_pkg::QWTWS_REG_STAT) ||
                 (i_paddr == qwtws_pkg::QWTWS_REG_RDAT);
  wire [31:0] rd_mux =
    (i_paddr == qwtws_pkg::QWTWS_REG_STAT) ?
      {29'h0, nack_r, done_r, busy} :
    (i_paddr == qwtws_pkg::QWTWS_REG_RDAT) ? {24'h0, rdat_r} : 32'h0;
  // Next byte to send after one completes
  wire [7:0] next_tx = (byte_r == 2'h0) ? ins_r : dat_r;

  // APB answers in the access cycle itself
  assign o_pready  = 1'h1;
  assign o_pslverr = i_psel && i_penable && !mapped;
  assign o_prdata  = rd_mux;

  // Link driver and sequencer
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      st_r <= QWTWS_M_IDLE;
      div_r <= 8'h00;
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      ins_r <= 8'h00;
      dat_r <= 8'h00;
      addr_r <= 7'h00;
      rd_r <= 1'h0;
      nodata_r <= 1'h0;
      nack_r <= 1'h0;
      scl_r <= 1'h1;
      sda_r <= 1'h1;
      done_r <= 1'h0;
      rdat_r <= 8'h00;
    end
    else if (go)
    begin
      // Command: go, read, no-data, address, instruction, data
      addr_r   <= i_pwdata[qwtws_pkg::QWTWS_CMD_ADDR_POS +: 7];
      ins_r    <= i_pwdata[qwtws_pkg::QWTWS_CMD_INS_POS +: 8];
      dat_r    <= i_pwdata[7:0];
      rd_r     <= i_pwdata[qwtws_pkg::QWTWS_CMD_RD_POS];
      nodata_r <= i_pwdata[qwtws_pkg::QWTWS_CMD_NODATA];
      tx_r     <= {i_pwdata[qwtws_pkg::QWTWS_CMD_ADDR_POS +: 7],
                   i_pwdata[qwtws_pkg::QWTWS_CMD_RD_POS]};
      nack_r <= 1'h0;
      done_r <= 1'h0;
      byte_r <= 2'h0;
      bit_r <= 4'h0;
      // Start: data falls while the clock is still high
      sda_r <= 1'h0;
      div_r <= qwtws_pkg::QWTWS_HALF_CYC;
      st_r  <= QWTWS_M_START;
    end
    else if (busy && !tick)
      div_r <= div_r - 8'h01;
    else if (busy)
    begin
      div_r <= qwtws_pkg::QWTWS_HALF_CYC;
      case (st_r)
        QWTWS_M_START, QWTWS_M_HIGH:
        begin
          // Clock falls; then put out the slot's data
          scl_r <= 1'h0;
          if (st_r == QWTWS_M_HIGH && ack_slot)
          begin
            bit_r <= 4'h0;
            byte_r <= byte_r + 2'h1;
            if (nack_r || last_byte)
            begin
              sda_r <= 1'h0;
              st_r <= QWTWS_M_STOP0;
            end
            else
            begin
              tx_r <= next_tx;
              // Reading: release so the slave owns the first data bit
              sda_r <= rd_r ? 1'h1 : next_tx[7];
              st_r <= QWTWS_M_BIT;
            end
          end
          else
          begin
            if (st_r == QWTWS_M_HIGH)
              bit_r <= bit_r + 4'h1;
            // Ack slot: release, or ack a read byte that is not the last
            if (st_r == QWTWS_M_HIGH && bit_r == 4'h7)
              sda_r <= !(rd_r && byte_r != 2'h0 && !last_byte);
            else if (rd_r && byte_r != 2'h0)
              sda_r <= 1'h1;
            else
              sda_r <= (st_r == QWTWS_M_START) ? tx_r[7] : tx_r[6];
            if (st_r == QWTWS_M_HIGH && bit_r != 4'h7)
              tx_r <= {tx_r[6:0], 1'h0};
            st_r <= QWTWS_M_BIT;
          end
        end
        QWTWS_M_BIT:
        begin
          scl_r <= 1'h1;
          st_r <= QWTWS_M_HIGH;
        end
        QWTWS_M_STOP0:
        begin
          scl_r <= 1'h1;
          st_r <= QWTWS_M_STOP1;
        end
        QWTWS_M_STOP1:
        begin
          sda_r <= 1'h1;
          done_r <= 1'h1;
          st_r <= QWTWS_M_IDLE;
        end
        default:
        begin
          st_r <= QWTWS_M_IDLE;
        end
      endcase
      // Sample the wire while clock is high, just before it falls
      if (st_r == QWTWS_M_HIGH)
      begin
        if (ack_slot && byte_r != 2'h0 && rd_r)
          rdat_r <= rx_r;
        else if (ack_slot && (byte_r == 2'h0 || !rd_r) && bus.sda)
          nack_r <= 1'h1;
        else if (!ack_slot)
          rx_r <= {rx_r[6:0], bus.sda};
      end
    end
  end

  // Open-drain: only pull low
  assign bus.scl_o    = 1'h0;
  assign bus.scl_oe   = !scl_r;
  // Data moves one clock after the clock falls, never with it
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
      sda_q_r <= 1'h1;
    else
      sda_q_r <= sda_r;
  end

  assign bus.sda_m_o  = 1'h0;
  assign bus.sda_m_oe = !sda_q_r;
endmodule : qwtws_master

/* verif/qwtws_props.sv */
`timescale 1ns/1ps
// Watches the open-drain link between the two ends
module qwtws_props (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // Link drives and wires
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_d_r;     // Clock wire one cycle ago
  logic       sda_d_r;     // Data wire one cycle ago
  logic [4:0] bit_cnt_r;   // Clock rises since start, saturating
  logic [4:0] bit_cnt_nxt; // Next count
  wire        start_w = scl && scl_d_r && sda_d_r && !sda; // Start seen
  wire        rise_w  = scl && !scl_d_r;                   // Clock rise
  // Saturate so long reads never wrap into the ack slot
  assign bit_cnt_nxt = start_w ? 5'h00 :
    (rise_w && bit_cnt_r != 5'h1f) ? bit_cnt_r + 5'h01 : bit_cnt_r;
  // Helper history, short on purpose
  always_ff @(posedge i_sys_clk)
  begin
    scl_d_r   <= scl;
    sda_d_r   <= sda;
    bit_cnt_r <= i_nrst ? bit_cnt_nxt : 5'h00;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // One full clock pulse, high then low
  sequence scl_pulse_s;
    ##[1:16] $rose(scl) ##[1:16] $fell(scl);
  endsequence
  // Data rising while clock high
  sequence stop_s;
    $rose(sda) && scl && $past(scl);
  endsequence
  reset_release_a: assert property ($rose(i_nrst) |->
    !scl_oe && !sda_m_oe && !sda_s_oe) else $error("bus held at reset");
  slave_pull_a: assert property (sda_s_oe |-> !sda)
    else $error("slave drive did not pull data low");
  scl_low_a: assert property (scl_oe |-> !scl)
    else $error("clock drive did not pull clock low");
  half_period_a: assert property ($changed(scl_oe) |=>
    $stable(scl_oe)[*3]) else $error("clock half period too short");
  slave_edge_a: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave data changed while clock high");
  start_master_a: assert property (($fell(sda) && scl && $past(scl))
    |-> sda_m_oe) else $error("start not made by master");
  addr_ack_a: assert property (($rose(sda_s_oe) && bit_cnt_r < 5'h09)
    |-> bit_cnt_r == 5'h08) else $error("address ack not in ninth slot");
  ack_hold_a: assert property ($rose(sda_s_oe) |->
    sda_s_oe throughout scl_pulse_s) else $error("slave bit dropped early");
  no_clash_a: assert property ((scl && sda_s_oe) |-> !sda_m_oe)
    else $error("both ends drive data");
  stop_idle_a: assert property (stop_s |=> scl[*3])
    else $error("clock not released after stop");
  od_level_a: assert property (!scl_o && !sda_m_o && !sda_s_o)
    else $error("open-drain level not low");
endmodule : qwtws_props

/* verif/tb_quad_wiper_two_wire_slave.sv */
`timescale 1ns/1ps
// Master and slave joined over one link, driven from APB
module tb_quad_wiper_two_wire_slave;
  logic        i_sys_clk = 1'h0;  // 10 MHz clock
  logic        i_nrst    = 1'h0;  // Synchronous reset
  logic        psel      = 1'h0;  // APB select
  logic        penable   = 1'h0;  // APB enable
  logic        pwrite    = 1'h0;  // APB direction
  logic [7:0]  paddr     = 8'h00; // APB address
  logic [31:0] pwdata    = '0;    // APB write data
  logic        sel_pin   = 1'h1;  // Interface select
  logic        pin_lo    = 1'h0;  // Address pin, bit 0
  logic        pin_hi    = 1'h1;  // Address pin, bit 1
  logic        gpd_n     = 1'h1;  // Global power down, low active
  wire  [31:0] prdata;            // APB read data
  wire         pready;            // APB ready
  wire         pslverr;           // APB error
  wire  [31:0] wiper;             // Four wiper registers
  wire  [3:0]  pd;                // Power down per channel
  wire         out1;              // First logic output
  wire         out2;              // Second logic output
  int          n_mismatch = 0;    // Mismatch count
  int          n_tests = 0;       // Comparison count
  int          cyc = 0;           // Cycle count for timeout
  int unsigned seed;              // Seed result
  logic [7:0]  exp_w [4];         // Expected wipers
  logic [3:0]  exp_pd;            // Expected per-channel power down
  logic        exp_o1;            // Expected first output
  logic        exp_o2;            // Expected second output
  logic [1:0]  exp_sel;           // Channel a read returns
  qwtws_if qwtws_if_inst ();
  qwtws_slave qwtws_slave_inst (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .i_interface_select_pin(sel_pin), .i_bus_addr_pin_low(pin_lo),
    .i_bus_addr_pin_high(pin_hi), .i_global_power_down_n(gpd_n),
    .bus(qwtws_if_inst), .o_wiper_register(wiper), .o_power_down(pd),
    .o_logic_out_first(out1), .o_logic_out_second(out2));
  qwtws_master qwtws_master_inst (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .bus(qwtws_if_inst));
  qwtws_props qwtws_props_inst (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .scl_o(qwtws_if_inst.scl_o), .scl_oe(qwtws_if_inst.scl_oe),
    .sda_m_o(qwtws_if_inst.sda_m_o), .sda_m_oe(qwtws_if_inst.sda_m_oe),
    .sda_s_o(qwtws_if_inst.sda_s_o), .sda_s_oe(qwtws_if_inst.sda_s_oe),
    .scl(qwtws_if_inst.scl), .sda(qwtws_if_inst.sda));
  // Free-running clock
  always #50 i_sys_clk = ~i_sys_clk;
  // Verdict and end of run
  task complete_run();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // Cuts a hang short
  always @(posedge i_sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  // Byte comparison
  task chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte
  // Bit comparison
  task chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_bit
  // One APB transfer; no wait count assumed
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd, output logic er);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge i_sys_clk);
    penable <= 1'h1;
    @(posedge i_sys_clk);
    while (pready !== 1'h1) @(posedge i_sys_clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge i_sys_clk);
  endtask : apb
  // Start a link transfer and poll until done
  task run(input logic rdn, nod, input logic [6:0] ad,
           input logic [7:0] ins, dat, output logic nk, output logic [7:0] rb);
    logic [31:0] d;
    logic        e;
    apb(1'h1, qwtws_pkg::QWTWS_REG_CMD,
        {1'h1, rdn, nod, 6'h00, ad, ins, dat}, d, e);
    do apb(1'h0, qwtws_pkg::QWTWS_REG_STAT, '0, d, e); while (d[1] !== 1'h1);
    nk = d[2];
    apb(1'h0, qwtws_pkg::QWTWS_REG_RDAT, '0, d, e);
    rb = d[7:0];
  endtask : run
  // Own address from the pins
  function logic [6:0] my_addr();
    return {qwtws_pkg::QWTWS_ADDR_FIXED, pin_hi, pin_lo};
  endfunction : my_addr
  // Instruction byte; ignored top and bottom bits are random
  function logic [7:0] mk_ins(input logic [1:0] ch, input logic m, p, o2, o1);
    return {1'($urandom), ch, m, p, o2, o1, 1'($urandom)};
  endfunction : mk_ins
  // Compare all device state with the model
  task check_state();
    for (int c = 0; c < 4; c++)
      chk_byte("wiper", exp_w[c], wiper[8*c +: 8]);
    chk_byte("power down", {4'h0, exp_pd | {4{~gpd_n}}}, {4'h0, pd});
    chk_bit("out first", exp_o1, out1);
    chk_bit("out second", exp_o2, out2);
  endtask : check_state
  // Accepted write, model updated
  task wr(input logic [1:0] ch, input logic m, p, nod, input logic [7:0] dat);
    logic       o1;
    logic       o2;
    logic       nk;
    logic [7:0] rb;
    o1 = 1'($urandom);
    o2 = 1'($urandom);
    run(1'h0, nod, my_addr(), mk_ins(ch, m, p, o2, o1), dat, nk, rb);
    chk_bit("write nack", 1'h0, nk);
    exp_sel = ch;
    exp_o1 = o1;
    exp_o2 = o2;
    exp_pd[ch] = p;
    if (m) exp_w[ch] = qwtws_pkg::QWTWS_MIDSCALE;
    if (!nod) exp_w[ch] = dat;
    check_state();
  endtask : wr
  // Read back the selected channel
  task rd_chk();
    logic       nk;
    logic [7:0] rb;
    run(1'h1, 1'h0, my_addr(), 8'($urandom), 8'($urandom), nk, rb);
    chk_bit("read nack", 1'h0, nk);
    chk_byte("read data", exp_w[exp_sel], rb);
  endtask : rd_chk
  // Transfer that must be ignored
  task bad(input logic [6:0] ad);
    logic       nk;
    logic [7:0] rb;
    run(1'h0, 1'h0, ad, mk_ins(2'h2, 1'h1, 1'h1, 1'h1, 1'h1), 8'h5a, nk, rb);
    chk_bit("ignored nack", 1'h1, nk);
    check_state();
  endtask : bad
  // Main sequence
  initial
  begin
    logic [31:0] d;
    logic        e;
    seed = $urandom(28);
    repeat (8) @(posedge i_sys_clk);
    i_nrst <= 1'h1;
    repeat (4) @(posedge i_sys_clk);
    for (int c = 0; c < 4; c++) exp_w[c] = 8'h80;
    {exp_pd, exp_o1, exp_o2, exp_sel} = '0;
    check_state();
    rd_chk();
    apb(1'h0, 8'h0c, '0, d, e);
    chk_bit("unmapped error", 1'h1, e);
    for (int c = 0; c < 4; c++)
    begin
      {pin_hi, pin_lo} <= 2'(c);
      @(posedge i_sys_clk);
      wr(2'(c), 1'h0, 1'h0, 1'h0, 8'($urandom));
      rd_chk();
    end
    wr(2'h3, 1'h0, 1'h0, 1'h0, 8'hff);
    wr(2'h0, 1'h0, 1'h0, 1'h0, 8'h00);
    rd_chk();
    wr(2'h1, 1'h1, 1'h0, 1'h1, 8'($urandom));
    rd_chk();
    wr(2'h2, 1'h0, 1'h1, 1'h0, 8'($urandom));
    gpd_n <= 1'h0;
    // Pin passes three stages and the filter before it acts
    repeat (6) @(posedge i_sys_clk);
    check_state();
    gpd_n <= 1'h1;
    wr(2'h2, 1'h0, 1'h0, 1'h1, 8'h00);
    wr(2'h3, 1'h0, 1'h0, 1'h1, 8'($urandom));
    rd_chk();
    bad({qwtws_pkg::QWTWS_ADDR_FIXED, ~pin_hi, pin_lo});
    bad({~qwtws_pkg::QWTWS_ADDR_FIXED[4],
         qwtws_pkg::QWTWS_ADDR_FIXED[3:0], pin_hi, pin_lo});
    sel_pin <= 1'h0;
    @(posedge i_sys_clk);
    bad(my_addr());
    sel_pin <= 1'h1;
    repeat (6)
    begin
      wr(2'($urandom), 1'h0, 1'($urandom), 1'h0, 8'($urandom));
      rd_chk();
    end
    complete_run();
  end
endmodule : tb_quad_wiper_two_wire_slave
